// ---- inc/cts_pkg.sv ----
/*
 per-context tlb sync and translation control: shared constants.
 assumes apb with 32-bit data; offsets are byte addresses within the context page.
*/
package cts_pkg;
   // register byte offsets
   localparam logic [11:0] CTS_OFF_CTRL     = 12'h030;
   localparam logic [11:0] CTS_OFF_SYNC     = 12'h7F0;
   localparam logic [11:0] CTS_OFF_STATUS   = 12'h7F4;
   localparam logic [11:0] CTS_OFF_IRQ_STAT = 12'h800;
   localparam logic [11:0] CTS_OFF_IRQ_CLR  = 12'h804;
   localparam logic [11:0] CTS_OFF_IRQ_EN   = 12'h808;
   localparam logic [11:0] CTS_OFF_CFG      = 12'h80C;
   // translation control field positions
   localparam int CTS_B_EXT     = 31;
   localparam int CTS_B_NS1     = 30;
   localparam int CTS_B_SHR1_HI = 29;
   localparam int CTS_B_SHR1_LO = 28;
   localparam int CTS_B_OC1_HI  = 27;
   localparam int CTS_B_OC1_LO  = 26;
   localparam int CTS_B_NS0     = 14;
   localparam int CTS_B_WD1     = 5;
   localparam int CTS_B_WD0     = 4;
   localparam int CTS_B_SZ_HI  = 2;
   // writable bits in short and long layouts
   localparam logic [31:0] CTS_MASK_SHORT = 32'hC000_4037;
   localparam logic [31:0] CTS_MASK_LONG  = 32'hFC00_4037;
   // config register bit positions (stage2, wide scheme, hypervisor, secure)
   localparam int CTS_C_S2  = 0;
   localparam int CTS_C_W64 = 1;
   localparam int CTS_C_HYP = 2;
   localparam int CTS_C_SEC = 3;
   // interrupt status bit positions
   localparam int CTS_I_DONE = 0;
   localparam int CTS_I_ACC  = 1;
   // reset values
   localparam logic [31:0] CTS_CTRL_RST = 32'h0000_0000;
   localparam logic [3:0]  CTS_CFG_RST  = 4'h0;
   // sync engine states
   typedef enum logic [1:0] {
      CTS_IDLE = 2'b00,
      CTS_WAIT = 2'b01
   } cts_state_e;
endpackage

// ---- verilog/cts_ctrl.sv ----
/*
 per-context tlb sync engine and translation control register behind apb.
 assumes an invalidate engine outside that reports accept and completion pulses
 for this context only, and a walker that consumes the decoded control outputs.
*/
// Contract
// R1: sync completes only after all earlier accepted invalidates of this context finished
// R2: sync waits only on this context's invalidates, never other banks
// R3: sync trigger is write-only, reads zero, data ignored
// R4: translation control is 32-bit read-write; software must program it
// R5: control settings choose which table base feeds the walk on a miss; the code takes the base from miss_upper alone
// R6: control field layout depends on wide-scheme select and extended address enable
// R7: effective extended enable is stored bit or stage2 or wide scheme or hypervisor
// R8: bit 31 selects short format when 0, long format when 1
// R9: stage2 and hypervisor long contexts treat extended enable as 1
// R10: bits 30 and 14 give walk non-secure attributes, only in secure banks
// R11: bit 5 set makes base-1 miss fault without walking
// R12: bit 4 does the same for base-0 addresses
// R13: short layout bits 2:0 hold region0 size offset; bit 3 reserved zero
// R14: long layout bits 29:28 hold base-1 walk shareability
// R15: long layout bits 27:26 hold base-1 walk outer cacheability
// R16: read-only status bit 0 shows sync still pending, resets to 0
// R17: software polls the status flag after triggering until it reads zero
`timescale 1ns/1ns
module cts_ctrl
   import cts_pkg::*;
#(
   parameter int CNT_W = 8
) (
   // clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // invalidate tracking for this context
   input  wire logic        inv_accept,
   input  wire logic        inv_done,
   // walk request from tlb miss
   input  wire logic        miss_valid,
   input  wire logic        miss_upper,
   // walk decisions
   output logic             walk_start,
   output logic             walk_fault,
   output logic             walk_base1,
   output logic             walk_nonsecure,
   output logic [1:0]       walk1_shareability,
   output logic [1:0]       walk1_outer_cacheability,
   output logic [2:0]       region0_size_offset,
   output logic             ext_addr_eff,
   // interrupt
   output logic             irq
);
   logic [31:0]      translation_control;
   logic [3:0]       cfg;
   logic [CNT_W-1:0] outstanding;   // invalidates accepted, not yet done
   logic [CNT_W-1:0] sync_remain;   // ones that predate the latest sync
   logic             sync_pending_flag;
   logic [1:0]       irq_stat;
   logic [1:0]       irq_en;
   logic             done_evt;
   logic             acc_evt;
   cts_state_e       state;

   // apb write strobe in the access phase; zero wait states
   logic wr;
   assign wr = psel && penable && pwrite && clk_en;

   // effective extended enable and layout choice
   logic ext_eff;
   logic [31:0] wmask;
   assign ext_eff = translation_control[CTS_B_EXT] | cfg[CTS_C_S2] | cfg[CTS_C_W64]
                  | cfg[CTS_C_HYP]; // R7 R9
   assign wmask = ext_eff ? CTS_MASK_LONG : CTS_MASK_SHORT; // R6 R8

   // byte-lane merge for control write
   logic [31:0] bmask;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         bmask[i*8 +: 8] = {8{pstrb[i]}};
      end
   end

   // translation control register; reserved bits forced to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         translation_control <= CTS_CTRL_RST;
      end else if (wr && paddr == CTS_OFF_CTRL) begin
         translation_control <= ((pwdata & bmask) | (translation_control & ~bmask))
                                & wmask; // R4 R13
      end
   end

   // context config register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= CTS_CFG_RST;
      end else if (wr && paddr == CTS_OFF_CFG && pstrb[0]) begin
         cfg <= pwdata[3:0];
      end
   end

   // outstanding invalidate count for this context only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         outstanding <= '0;
      end else if (clk_en) begin
         outstanding <= outstanding + CNT_W'(inv_accept) - CNT_W'(inv_done); // R2
      end
   end

   // sync engine: snapshot count at trigger, drain by completions
   logic trig;
   assign trig = wr && paddr == CTS_OFF_SYNC; // R3
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state       <= CTS_IDLE;
         sync_remain <= '0;
      end else if (clk_en) begin
         if (trig) begin
            // invalidates completing this cycle are already not owed
            sync_remain <= outstanding - CNT_W'(inv_done); // R1
            state       <= (outstanding - CNT_W'(inv_done) == '0) ? CTS_IDLE : CTS_WAIT;
         end else begin
            case (state)
               CTS_IDLE: state <= CTS_IDLE;
               CTS_WAIT: begin
                  if (inv_done) begin
                     sync_remain <= sync_remain - CNT_W'(1);
                     if (sync_remain == CNT_W'(1)) state <= CTS_IDLE; // R1
                  end
               end
               default: state <= CTS_IDLE;
            endcase
         end
      end
   end

   // pending flag seen by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_pending_flag <= 1'b0;
      end else if (clk_en) begin
         if (trig) begin
            sync_pending_flag <= (outstanding - CNT_W'(inv_done)) != '0; // R16
         end else if (state == CTS_WAIT && inv_done && sync_remain == CNT_W'(1)) begin
            sync_pending_flag <= 1'b0; // R16
         end
      end
   end

   // interrupt events: sync finished, sync accepted
   assign done_evt = clk_en && state == CTS_WAIT && !trig && inv_done
                     && sync_remain == CNT_W'(1);
   assign acc_evt  = trig;

   // sticky status, set wins over clear
   logic clr;
   assign clr = wr && paddr == CTS_OFF_IRQ_CLR;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= 2'b00;
      end else if (clk_en) begin
         irq_stat <= (irq_stat & ~(clr ? pwdata[1:0] : 2'b00)) | {acc_evt, done_evt};
      end
   end

   // interrupt enable register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en <= 2'b00;
      end else if (wr && paddr == CTS_OFF_IRQ_EN) begin
         irq_en <= pwdata[1:0];
      end
   end

   // interrupt output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= |(irq_stat & irq_en);
      end
   end

   // read mux; unmapped reads zero with error
   logic [31:0] next_prdata;
   logic        next_err;
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_err    = 1'b0;
      case (paddr)
         CTS_OFF_CTRL:     next_prdata = translation_control;
         CTS_OFF_SYNC:     next_prdata = 32'h0000_0000; // R3
         CTS_OFF_STATUS:   next_prdata = {31'h0, sync_pending_flag}; // R16
         CTS_OFF_IRQ_STAT: next_prdata = {30'h0, irq_stat};
         CTS_OFF_IRQ_CLR:  next_prdata = 32'h0000_0000;
         CTS_OFF_IRQ_EN:   next_prdata = {30'h0, irq_en};
         CTS_OFF_CFG:      next_prdata = {28'h0, cfg};
         default:          next_err    = 1'b1;
      endcase
   end

   // apb answer: registered, zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready  <= psel && !penable;
         prdata  <= (psel && !penable && !pwrite) ? next_prdata : 32'h0000_0000;
         pslverr <= psel && !penable && next_err;
      end
   end

   // walk decision per miss
   logic pd_hit;
   assign pd_hit = miss_upper ? translation_control[CTS_B_WD1]   // R11
                              : translation_control[CTS_B_WD0];  // R12
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         walk_start     <= 1'b0;
         walk_fault     <= 1'b0;
         walk_base1     <= 1'b0;
         walk_nonsecure <= 1'b0;
      end else if (clk_en) begin
         walk_start     <= miss_valid && !pd_hit; // R11 R12
         walk_fault     <= miss_valid && pd_hit;
         walk_base1     <= miss_upper; // R5
         walk_nonsecure <= cfg[CTS_C_SEC]
                          && (miss_upper ? translation_control[CTS_B_NS1]
                                         : translation_control[CTS_B_NS0]); // R10
      end
   end

   // decoded attribute outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         walk1_shareability       <= 2'b00;
         walk1_outer_cacheability <= 2'b00;
         region0_size_offset      <= 3'b000;
         ext_addr_eff             <= 1'b0;
      end else if (clk_en) begin
         walk1_shareability       <= ext_eff ? translation_control[CTS_B_SHR1_HI:CTS_B_SHR1_LO]
                                             : 2'b00; // R14
         walk1_outer_cacheability <= ext_eff ? translation_control[CTS_B_OC1_HI:CTS_B_OC1_LO]
                                             : 2'b00; // R15
         region0_size_offset      <= translation_control[CTS_B_SZ_HI:0]; // R13
         ext_addr_eff             <= ext_eff; // R7 R8
      end
   end

   // checks
   property p_sync_clears;
      @(posedge pclk) disable iff (!presetn)
      (done_evt) |=> !sync_pending_flag;
   endproperty
   a_sync_clears: assert property (p_sync_clears) else $error("flag not cleared"); // R1

   property p_trig_empty;
      @(posedge pclk) disable iff (!presetn)
      (trig && outstanding == '0) |=> !sync_pending_flag;
   endproperty
   a_trig_empty: assert property (p_trig_empty) else $error("empty sync pending"); // R2

   property p_sync_reads_zero;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && psel && !penable && !pwrite && paddr == CTS_OFF_SYNC) |=> prdata == 32'h0;
   endproperty
   a_sync_reads_zero: assert property (p_sync_reads_zero) else $error("sync read nonzero"); // R3

   property p_ext_forced;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && (cfg[CTS_C_S2] || cfg[CTS_C_HYP])) |=> ext_addr_eff;
   endproperty
   a_ext_forced: assert property (p_ext_forced) else $error("extended enable low"); // R9

   property p_wd1;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && miss_valid && miss_upper && translation_control[CTS_B_WD1])
         |=> walk_fault && !walk_start;
   endproperty
   a_wd1: assert property (p_wd1) else $error("base1 walk while disabled"); // R11

   property p_wd0;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && miss_valid && !miss_upper && !translation_control[CTS_B_WD0])
         |=> walk_start && !walk_fault;
   endproperty
   a_wd0: assert property (p_wd0) else $error("base0 walk missing"); // R12

   property p_ns;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !cfg[CTS_C_SEC]) |=> !walk_nonsecure;
   endproperty
   a_ns: assert property (p_ns) else $error("ns in nonsecure bank"); // R10

   property p_bit3;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |-> !translation_control[3];
   endproperty
   a_bit3: assert property (p_bit3) else $error("reserved bit set"); // R13

   property p_sync_starts;
      @(posedge pclk) disable iff (!presetn)
      (trig && outstanding != CNT_W'(inv_done)) |=> sync_pending_flag;
   endproperty
   a_sync_starts: assert property (p_sync_starts) else $error("sync not pending"); // R16

   property p_sync_holds;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && sync_pending_flag && !trig && !inv_done) |=> sync_pending_flag;
   endproperty
   a_sync_holds: assert property (p_sync_holds) else $error("sync ended early"); // R1

   property p_trig_keeps_ctrl;
      @(posedge pclk) disable iff (!presetn)
      (trig) |=> $stable(translation_control);
   endproperty
   a_trig_keeps_ctrl: assert property (p_trig_keeps_ctrl) else $error("sync data stored"); // R3

   property p_wd1_walks;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && miss_valid && miss_upper && !translation_control[CTS_B_WD1])
         |=> walk_start && !walk_fault;
   endproperty
   a_wd1_walks: assert property (p_wd1_walks) else $error("base1 walk missing"); // R11

   property p_wd0_faults;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && miss_valid && !miss_upper && translation_control[CTS_B_WD0])
         |=> walk_fault && !walk_start;
   endproperty
   a_wd0_faults: assert property (p_wd0_faults) else $error("base0 walk while disabled"); // R12

   property p_base1;
      @(posedge pclk) disable iff (!presetn)
      (clk_en) |=> walk_base1 == $past(miss_upper);
   endproperty
   a_base1: assert property (p_base1) else $error("wrong table base"); // R5

   property p_ns1;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && cfg[CTS_C_SEC] && miss_upper && translation_control[CTS_B_NS1]) |=> walk_nonsecure;
   endproperty
   a_ns1: assert property (p_ns1) else $error("base1 walk not nonsecure"); // R10

   property p_wide;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && cfg[CTS_C_W64]) |=> ext_addr_eff;
   endproperty
   a_wide: assert property (p_wide) else $error("wide scheme without extended enable"); // R7

   property p_shr_short;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !ext_eff) |=> walk1_shareability == 2'h0;
   endproperty
   a_shr_short: assert property (p_shr_short) else $error("shareability in short layout"); // R14

   property p_oc_short;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !ext_eff) |=> walk1_outer_cacheability == 2'h0;
   endproperty
   a_oc_short: assert property (p_oc_short) else $error("cacheability in short layout"); // R15

   property p_size;
      @(posedge pclk) disable iff (!presetn)
      (clk_en) |=> region0_size_offset == $past(translation_control[CTS_B_SZ_HI:0]);
   endproperty
   a_size: assert property (p_size) else $error("size offset mismatch"); // R13
endmodule // cts_ctrl

// ---- tb/tb_top.sv ----
/*
 self-checking bench for the per-context tlb sync and translation control block.
 assumes cts_pkg and cts_ctrl are compiled first; apb answers are awaited, never assumed.
*/
`timescale 1ns/1ns
module tb_top;
   import cts_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        inv_accept, inv_done, miss_valid, miss_upper, irq, clk_en;
   logic        walk_start, walk_fault, walk_base1, walk_nonsecure, ext_addr_eff;
   logic [1:0]  shr1, oc1;
   logic [2:0]  sz0;
   int          failures, checks, cycles;

   // device under test, byte strobes held on
   cts_ctrl #(.CNT_W(8)) cts_ctrl_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .inv_accept(inv_accept), .inv_done(inv_done), .miss_valid(miss_valid),
      .miss_upper(miss_upper), .walk_start(walk_start), .walk_fault(walk_fault),
      .walk_base1(walk_base1), .walk_nonsecure(walk_nonsecure), .walk1_shareability(shr1),
      .walk1_outer_cacheability(oc1), .region0_size_offset(sz0),
      .ext_addr_eff(ext_addr_eff), .irq(irq));

   // 250 MHz clock and a watchdog on the whole run
   initial pclk = 1'b0;
   always #2 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         summarize();
      end
   end

   task automatic summarize;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer: setup, access held until pready seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask

   // let registered outputs land, then look just after the edge
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   // one-cycle invalidate accept/done pulses
   task automatic ev(input logic acc, input logic dn);
      @(posedge pclk);
      inv_accept <= acc;
      inv_done <= dn;
      @(posedge pclk);
      inv_accept <= 1'b0;
      inv_done <= 1'b0;
   endtask

   // tlb miss pulse; exp is {walk_start, walk_fault}
   task automatic miss(input logic up, input logic [1:0] exp);
      @(posedge pclk);
      miss_valid <= 1'b1;
      miss_upper <= up;
      @(posedge pclk);
      miss_valid <= 1'b0;
      #1;
      chk(32'({walk_start, walk_fault, walk_base1}), 32'({exp, up}));
   endtask

   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, inv_accept, inv_done, miss_valid, miss_upper} = '0;
      paddr = '0;
      clk_en = 1'b1;
      pwdata = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(CTS_OFF_STATUS, 32'h0000_0000);
      apb(1'b0, 12'h100, 32'h0000_0000);
      chk(32'(err), 32'h0000_0001);
      chk(rd, 32'h0000_0000);
      $display("test reset and unmapped done");
      // short layout then long layout of the control register
      apb(1'b1, CTS_OFF_CTRL, 32'h7FFF_FFFF);
      rdchk(CTS_OFF_CTRL, 32'h4000_4037);
      settle(2);
      chk(32'({ext_addr_eff, shr1, oc1, sz0}), 32'h0000_0007);
      apb(1'b1, CTS_OFF_CTRL, 32'h8000_0000);
      apb(1'b1, CTS_OFF_CTRL, 32'hFFFF_FFFF);
      rdchk(CTS_OFF_CTRL, 32'hFC00_4037);
      settle(2);
      chk(32'({ext_addr_eff, shr1, oc1, sz0}), 32'h0000_00FF);
      $display("test control layout done");
      // effective extended enable from stage 2, wide scheme and hypervisor
      apb(1'b1, CTS_OFF_CTRL, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, CTS_OFF_CFG, (i == 0) ? 32'h0 : (32'h1 << (i - 1)));
         settle(2);
         chk(32'(ext_addr_eff), 32'(i != 0));
      end
      $display("test effective extended enable done");
      // walk disable per base
      apb(1'b1, CTS_OFF_CFG, 32'h0000_0000);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, CTS_OFF_CTRL, (i != 0) ? 32'h0000_0010 : 32'h0000_0020);
         miss(1'b1, (i != 0) ? 2'b10 : 2'b01);
         miss(1'b0, (i != 0) ? 2'b01 : 2'b10);
      end
      // walk non-secure attribute only in a secure bank
      apb(1'b1, CTS_OFF_CFG, 32'h0000_0008);
      apb(1'b1, CTS_OFF_CTRL, 32'h4000_0000);
      miss(1'b1, 2'b10);
      settle(1);
      chk(32'(walk_nonsecure), 32'h1);
      apb(1'b1, CTS_OFF_CTRL, 32'h0000_4000);
      miss(1'b0, 2'b10);
      settle(1);
      chk(32'(walk_nonsecure), 32'h1);
      apb(1'b1, CTS_OFF_CFG, 32'h0000_0000);
      settle(2);
      chk(32'(walk_nonsecure), 32'h0);
      $display("test walk decisions done");
      // sync waits only on invalidates accepted before it
      apb(1'b1, CTS_OFF_IRQ_EN, 32'h0000_0001);
      ev(1'b1, 1'b0);
      ev(1'b1, 1'b0);
      apb(1'b1, CTS_OFF_SYNC, 32'hFFFF_FFFF);
      rdchk(CTS_OFF_SYNC, 32'h0000_0000);
      rdchk(CTS_OFF_STATUS, 32'h0000_0001);
      ev(1'b1, 1'b0);
      ev(1'b0, 1'b1);
      rdchk(CTS_OFF_STATUS, 32'h0000_0001);
      chk(32'(irq), 32'h0);
      ev(1'b0, 1'b1);
      rdchk(CTS_OFF_STATUS, 32'h0000_0000);
      settle(1);
      chk(32'(irq), 32'h1);
      rdchk(CTS_OFF_IRQ_STAT, 32'h0000_0003);
      apb(1'b1, CTS_OFF_IRQ_CLR, 32'h0000_0003);
      settle(2);
      chk(32'(irq), 32'h0);
      rdchk(CTS_OFF_IRQ_STAT, 32'h0000_0000);
      apb(1'b1, CTS_OFF_SYNC, 32'h0000_0000);
      rdchk(CTS_OFF_STATUS, 32'h0000_0001);
      ev(1'b0, 1'b1);
      rdchk(CTS_OFF_STATUS, 32'h0000_0000);
      // an accept while frozen is not counted, so an empty sync is done at once
      @(posedge pclk);
      clk_en <= 1'b0;
      ev(1'b1, 1'b0);
      @(posedge pclk);
      clk_en <= 1'b1;
      apb(1'b1, CTS_OFF_SYNC, 32'h0000_0000);
      rdchk(CTS_OFF_STATUS, 32'h0000_0000);
      $display("test sync done");
      summarize();
   end
endmodule // tb_top
